// [design/gci_pkg.sv]
// Constants, register map and carrier types for the gauge control input block.
package gci_pkg;

    localparam int         CLK_MHZ          = 100;
    localparam int         ADDR_W           = 4;

    localparam logic [3:0] ADDR_CONFIG      = 4'h0;
    localparam logic [3:0] ADDR_COMMAND     = 4'h4;
    localparam logic [3:0] ADDR_STATUS      = 4'h8;

    localparam logic [1:0] RESP_OKAY        = 2'h0;
    localparam logic [1:0] RESP_SLVERR      = 2'h2;

    localparam logic [1:0] SEL_DIGITAL      = 2'h0;
    localparam logic [1:0] SEL_PANEL        = 2'h1;
    localparam logic [1:0] SEL_SERIAL       = 2'h2;

    localparam logic [3:0] DEGAS_MIN_MINUTES = 4'h2;
    localparam logic [3:0] DEGAS_MAX_MINUTES = 4'hA;
    localparam logic [9:0] SECS_PER_MINUTE   = 10'h03C;

    localparam int         IN_GAUGE         = 0;
    localparam int         IN_DEGAS         = 1;
    localparam int         IN_EMIS          = 2;
    localparam int         IN_PANEL         = 3;
    localparam logic [5:0] PINS_RELEASED    = 6'h3F;

    localparam int         DEBOUNCE_US      = 10000;
    localparam int         DEBOUNCE_CYCLES  = DEBOUNCE_US * CLK_MHZ;
    localparam int         SECOND_US        = 1000000;
    localparam int         SECOND_CYCLES    = SECOND_US * CLK_MHZ;

    typedef struct packed {
        logic [3:0] degas_minutes;
        logic [1:0] control_interface_select;
    } gci_config_type;

    localparam gci_config_type CONFIG_RST = '{degas_minutes: 4'h2, control_interface_select: 2'h0};

    typedef struct packed {
        logic emis_high;
        logic gauge_on;
    } gci_cmd_type;

    localparam gci_cmd_type COMMAND_RST = '{emis_high: 1'b0, gauge_on: 1'b0};
    localparam int          CMD_DEGAS_BIT = 2;

    typedef struct packed {
        logic [9:0] secs_left;
        logic [5:0] inputs_active;
        logic       emis_high;
        logic       degas_active;
        logic       gauge_active;
    } gci_status_type;

endpackage : gci_pkg

// [design/gci_control.sv]
// Gauge control inputs: pin debouncing, interface selection, degas timer and AXI4-Lite registers.
//
// Functional notes
// RQ1: The gauge and filament stay on for as long as the gauge-on input is held at ground.
// RQ2: Releasing the ground on the gauge-on input turns the gauge and filament off.
// RQ3: Grounding the degas input starts a degas cycle.
// RQ4: A started degas cycle runs for the configured two to ten minutes even if the input is released.
// RQ5: A new degas cycle needs the degas input released and grounded again, so a held ground never retriggers.
// RQ6: The high emission current is selected while the emission input is grounded, the low one otherwise.
// RQ7: The degas status output transistor is on exactly while a degas cycle is active.
// RQ8: The gauge status output transistor is on exactly while the gauge and filament are active.
// RQ9: Only the configured control interface commands the unit and requests from the others are ignored.
// RQ10: Gauge, emission and degas are each controllable from the inputs, the serial commands or the panel.
// RQ11: After power-up the unit is off and stays off until explicitly activated.
// RQ12: Every discrete input is synchronised and debounced before it is acted upon.
//
// The register offsets and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ns
module gci_control #(
    parameter int DEBOUNCE_CYCLES = gci_pkg::DEBOUNCE_CYCLES,
    parameter int SECOND_CYCLES   = gci_pkg::SECOND_CYCLES
) (
    input  wire logic                       aclk,
    input  wire logic                       aresetn,
    input  wire logic [gci_pkg::ADDR_W-1:0] awaddr,
    input  wire logic                       awvalid,
    output logic                            awready,
    input  wire logic [31:0]                wdata,
    input  wire logic [3:0]                 wstrb,
    input  wire logic                       wvalid,
    output logic                            wready,
    output logic [1:0]                      bresp,
    output logic                            bvalid,
    input  wire logic                       bready,
    input  wire logic [gci_pkg::ADDR_W-1:0] araddr,
    input  wire logic                       arvalid,
    output logic                            arready,
    output logic [31:0]                     rdata,
    output logic [1:0]                      rresp,
    output logic                            rvalid,
    input  wire logic                       rready,
    input  wire logic [2:0]                 din_n,
    input  wire logic [2:0]                 panel_n,
    output logic                            filament_on,
    output logic                            emis_high,
    output logic                            degas_active,
    output logic                            gauge_stat_out,
    output logic                            gauge_stat_oe_n,
    output logic                            degas_stat_out,
    output logic                            degas_stat_oe_n
);

    localparam int DW = $clog2(DEBOUNCE_CYCLES + 1);
    localparam int TW = $clog2(SECOND_CYCLES + 1);

    // Compares the word index of an address with a register offset.
    function automatic logic addr_hit(input logic [gci_pkg::ADDR_W-1:0] a, input logic [3:0] off);
        return a[gci_pkg::ADDR_W-1:2] == off[gci_pkg::ADDR_W-1:2];
    endfunction : addr_hit

    // Clamps the configured duration to the legal range and converts it to seconds.
    function automatic logic [9:0] degas_secs(input logic [3:0] minutes);
        logic [3:0] m;
        m = minutes;
        if (m < gci_pkg::DEGAS_MIN_MINUTES) begin
            m = gci_pkg::DEGAS_MIN_MINUTES;
        end else if (m > gci_pkg::DEGAS_MAX_MINUTES) begin
            m = gci_pkg::DEGAS_MAX_MINUTES;
        end
        return 10'(10'(m) * gci_pkg::SECS_PER_MINUTE);
    endfunction : degas_secs

    logic [5:0]              pin_n;
    logic [5:0]              sync1_ff;
    logic [5:0]              sync2_ff;
    logic [5:0]              level_n;
    logic [5:0]              press;
    logic [5:0]              press_ff;
    logic [5:0]              press_edge;

    // Two flip-flops bring the pins into the clock domain.
    assign pin_n = {panel_n, din_n};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_ff <= gci_pkg::PINS_RELEASED;
            sync2_ff <= gci_pkg::PINS_RELEASED;
        end else begin
            sync1_ff <= pin_n; // [RQ12]
            sync2_ff <= sync1_ff;
        end
    end

    // A level is accepted once it has held unchanged for the debounce time.
    for (genvar i = 0; i < 6; i++) begin : g_deb
        logic [DW-1:0] cnt_ff;
        logic          stab_ff;
        wire           differ = sync2_ff[i] != stab_ff;
        wire           done   = cnt_ff == DW'(DEBOUNCE_CYCLES - 1);

        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                cnt_ff  <= '0;
                stab_ff <= 1'b1;
            end else begin
                cnt_ff  <= (!differ || done) ? '0 : DW'(cnt_ff + 1'b1); // [RQ12]
                stab_ff <= (differ && done) ? sync2_ff[i] : stab_ff;
            end
        end

        assign level_n[i] = stab_ff;
    end

    assign press      = ~level_n;
    assign press_edge = press & ~press_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            press_ff <= '0;
        end else begin
            press_ff <= press;
        end
    end

    gci_pkg::gci_config_type cfg_ff;
    gci_pkg::gci_cmd_type    cmd_ff;
    logic                    ser_degas_ff;
    logic                    gauge_ff;
    logic                    emis_ff;
    logic                    degas_ff;
    logic [9:0]              secs_ff;
    logic [TW-1:0]           tick_ff;

    wire sel_dig = cfg_ff.control_interface_select == gci_pkg::SEL_DIGITAL;
    wire sel_pan = cfg_ff.control_interface_select == gci_pkg::SEL_PANEL;
    wire sel_ser = cfg_ff.control_interface_select == gci_pkg::SEL_SERIAL;

    // Only the selected source steers the unit; an illegal select holds gauge and emission and starts no degas.
    wire nxt_gauge = sel_dig ? press[gci_pkg::IN_GAUGE] :                           // [RQ1] [RQ2]
                     sel_pan ? gauge_ff ^ press_edge[gci_pkg::IN_PANEL + gci_pkg::IN_GAUGE] :
                     sel_ser ? cmd_ff.gauge_on : gauge_ff;                          // [RQ9] [RQ10]
    wire nxt_emis  = sel_dig ? press[gci_pkg::IN_EMIS] :                            // [RQ6]
                     sel_pan ? emis_ff ^ press_edge[gci_pkg::IN_PANEL + gci_pkg::IN_EMIS] :
                     sel_ser ? cmd_ff.emis_high : emis_ff;                          // [RQ10]
    wire degas_req = sel_dig ? press_edge[gci_pkg::IN_DEGAS] :                      // [RQ3] [RQ5]
                     sel_pan ? press_edge[gci_pkg::IN_PANEL + gci_pkg::IN_DEGAS] :
                     sel_ser ? ser_degas_ff : 1'b0;                                 // [RQ9]

    wire degas_start = degas_req && !degas_ff;
    wire tick        = tick_ff == TW'(SECOND_CYCLES - 1);
    wire last_sec    = secs_ff == 10'h001;

    wire [TW-1:0] nxt_tick  = (!degas_ff || tick) ? '0 : TW'(tick_ff + 1'b1);
    wire [9:0]    nxt_secs  = degas_start ? degas_secs(cfg_ff.degas_minutes) :     // [RQ4]
                              (degas_ff && tick) ? 10'(secs_ff - 1'b1) : secs_ff;
    wire          nxt_degas = degas_start ? 1'b1 : (tick && last_sec) ? 1'b0 : degas_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gauge_ff <= 1'b0; // [RQ11]
            emis_ff  <= 1'b0;
            degas_ff <= 1'b0;
            secs_ff  <= '0;
            tick_ff  <= '0;
        end else begin
            gauge_ff <= nxt_gauge;
            emis_ff  <= nxt_emis;
            degas_ff <= nxt_degas; // [RQ4]
            secs_ff  <= nxt_secs;
            tick_ff  <= nxt_tick;
        end
    end

    assign filament_on     = gauge_ff;
    assign emis_high       = emis_ff;
    assign degas_active    = degas_ff;
    assign gauge_stat_out  = 1'b0;
    assign gauge_stat_oe_n = ~gauge_ff; // [RQ8]
    assign degas_stat_out  = 1'b0;
    assign degas_stat_oe_n = ~degas_ff; // [RQ7]

    logic                      aw_got_ff;
    logic                      w_got_ff;
    logic [gci_pkg::ADDR_W-1:0] awaddr_ff;
    logic [31:0]               wdata_ff;
    logic                      wstrb0_ff;
    logic                      bvalid_ff;
    logic [1:0]                bresp_ff;
    logic                      rvalid_ff;
    logic [1:0]                rresp_ff;
    logic [31:0]               rdata_ff;

    assign awready = !aw_got_ff && !bvalid_ff;
    assign wready  = !w_got_ff && !bvalid_ff;
    assign arready = !rvalid_ff;

    wire                       aw_hs    = awvalid && awready;
    wire                       w_hs     = wvalid && wready;
    wire                       ar_hs    = arvalid && arready;
    wire [gci_pkg::ADDR_W-1:0] wr_addr  = aw_hs ? awaddr : awaddr_ff;
    wire [31:0]                wr_data  = w_hs ? wdata : wdata_ff;
    wire                       wr_strb0 = w_hs ? wstrb[0] : wstrb0_ff;
    wire                       wr_go    = (aw_got_ff || aw_hs) && (w_got_ff || w_hs);

    wire wr_cfg  = wr_go && wr_strb0 && addr_hit(wr_addr, gci_pkg::ADDR_CONFIG);
    wire wr_cmd  = wr_go && wr_strb0 && addr_hit(wr_addr, gci_pkg::ADDR_COMMAND);
    wire wr_map  = addr_hit(wr_addr, gci_pkg::ADDR_CONFIG) || addr_hit(wr_addr, gci_pkg::ADDR_COMMAND)
                   || addr_hit(wr_addr, gci_pkg::ADDR_STATUS);

    gci_pkg::gci_status_type status;

    assign status = '{secs_left: secs_ff, inputs_active: press, emis_high: emis_ff,
                      degas_active: degas_ff, gauge_active: gauge_ff};

    wire        rd_cfg  = addr_hit(araddr, gci_pkg::ADDR_CONFIG);
    wire        rd_cmd  = addr_hit(araddr, gci_pkg::ADDR_COMMAND);
    wire        rd_stat = addr_hit(araddr, gci_pkg::ADDR_STATUS);
    wire [31:0] rd_data = rd_cfg  ? 32'(cfg_ff) :
                          rd_cmd  ? 32'(cmd_ff) :
                          rd_stat ? 32'(status) : 32'h0000_0000;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_ff <= 1'b0;
            w_got_ff  <= 1'b0;
            awaddr_ff <= '0;
            wdata_ff  <= '0;
            wstrb0_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff  <= gci_pkg::RESP_OKAY;
        end else begin
            aw_got_ff <= !wr_go && (aw_got_ff || aw_hs);
            w_got_ff  <= !wr_go && (w_got_ff || w_hs);
            awaddr_ff <= wr_addr;
            wdata_ff  <= wr_data;
            wstrb0_ff <= wr_strb0;
            bvalid_ff <= wr_go || (bvalid_ff && !bready);
            bresp_ff  <= wr_go ? (wr_map ? gci_pkg::RESP_OKAY : gci_pkg::RESP_SLVERR) : bresp_ff;
        end
    end

    // Serial commands land in the command register; its degas bit is a one-cycle request.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_ff       <= gci_pkg::CONFIG_RST;
            cmd_ff       <= gci_pkg::COMMAND_RST;
            ser_degas_ff <= 1'b0;
        end else begin
            cfg_ff       <= wr_cfg ? gci_pkg::gci_config_type'(wr_data[5:0]) : cfg_ff;
            cmd_ff       <= wr_cmd ? gci_pkg::gci_cmd_type'(wr_data[1:0]) : cmd_ff; // [RQ10]
            ser_degas_ff <= wr_cmd && wr_data[gci_pkg::CMD_DEGAS_BIT];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'b0;
            rresp_ff  <= gci_pkg::RESP_OKAY;
            rdata_ff  <= '0;
        end else begin
            rvalid_ff <= ar_hs || (rvalid_ff && !rready);
            rresp_ff  <= ar_hs ? ((rd_cfg || rd_cmd || rd_stat) ? gci_pkg::RESP_OKAY
                                                                 : gci_pkg::RESP_SLVERR) : rresp_ff;
            rdata_ff  <= ar_hs ? rd_data : rdata_ff;
        end
    end

    assign bvalid = bvalid_ff;
    assign bresp  = bresp_ff;
    assign rvalid = rvalid_ff;
    assign rresp  = rresp_ff;
    assign rdata  = rdata_ff;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_gauge_follows_pin: assert property ( // [RQ1]
        sel_dig && $past(sel_dig) |-> gauge_ff == $past(press[gci_pkg::IN_GAUGE]))
        else $error("Gauge does not follow the gauge-on input.");

    a_gauge_release_off: assert property ( // [RQ2]
        sel_dig ##1 sel_dig && $fell(press[gci_pkg::IN_GAUGE]) |=> !gauge_ff && gauge_stat_oe_n)
        else $error("Gauge stayed on after the input was released.");

    a_degas_pin_start: assert property ( // [RQ3]
        sel_dig && press_edge[gci_pkg::IN_DEGAS] && !degas_ff |=> degas_ff && secs_ff >= 10'h078)
        else $error("Degas did not start on a grounded degas input.");

    a_degas_runs_on: assert property ( // [RQ4]
        degas_ff && !(tick && last_sec) |=> degas_ff)
        else $error("Degas ended before its duration ran out.");

    a_degas_length: assert property ( // [RQ4]
        $rose(degas_ff) |-> secs_ff >= 10'h078 && secs_ff <= 10'h258)
        else $error("Degas duration outside two to ten minutes.");

    a_no_retrigger: assert property ( // [RQ5]
        sel_dig && $fell(degas_ff) && press[gci_pkg::IN_DEGAS] && press_ff[gci_pkg::IN_DEGAS]
        |=> !degas_ff)
        else $error("A held degas input retriggered a cycle.");

    a_emission_select: assert property ( // [RQ6]
        sel_dig && $past(sel_dig) |-> emis_high == $past(press[gci_pkg::IN_EMIS]))
        else $error("Emission select does not follow its input.");

    a_degas_status_pin: assert property ( // [RQ7]
        $rose(degas_ff) |-> !degas_stat_oe_n && $past(degas_stat_oe_n))
        else $error("Degas status output disagrees with the degas state.");

    a_gauge_status_pin: assert property ( // [RQ8]
        $changed(gauge_ff) |-> gauge_stat_oe_n == !gauge_ff && filament_on == gauge_ff)
        else $error("Gauge status output disagrees with the gauge state.");

    a_serial_ignores_pins: assert property ( // [RQ9]
        sel_ser && $past(sel_ser) |-> gauge_ff == $past(cmd_ff.gauge_on) && emis_ff == $past(cmd_ff.emis_high))
        else $error("Unselected interface changed the unit.");

    a_off_after_reset: assert property ( // [RQ11]
        $past(!aresetn) |-> !gauge_ff && !degas_ff && gauge_stat_oe_n && degas_stat_oe_n)
        else $error("Unit not off after reset.");

    a_debounce_hold: assert property ( // [RQ12]
        $changed(level_n[gci_pkg::IN_GAUGE]) |-> $past(g_deb[0].cnt_ff) == DW'(DEBOUNCE_CYCLES - 1))
        else $error("Input accepted before the debounce time.");

    c_gauge_on:     cover property (sel_dig && $rose(gauge_ff));
    c_degas_done:   cover property ($fell(degas_ff));
    c_serial_degas: cover property (sel_ser && ser_degas_ff ##1 degas_ff);
    c_panel_toggle: cover property (sel_pan && $fell(gauge_ff));

endmodule : gci_control

// [tb/gci_partner.sv]
// External controller model that grounds and releases the discrete input lines.
`timescale 1ns/1ns
module gci_partner (
    input  wire logic       aclk,
    input  wire logic [2:0] req,
    input  wire logic       chatter,
    input  wire logic       gauge_oe_n,
    input  wire logic       gauge_out,
    input  wire logic       degas_oe_n,
    input  wire logic       degas_out,
    output logic [2:0]      din_n,
    output logic            gauge_line,
    output logic            degas_line
);
    initial din_n = 3'h7;
    // A requested line is held at ground; a released line goes high through its pull-up.
    always @(posedge aclk) begin
        if (chatter) begin
            din_n <= {din_n[2:1], ~din_n[0]};
        end else begin
            din_n <= ~req;
        end
    end
    // A status line floats high unless its transistor conducts.
    assign gauge_line = gauge_oe_n ? 1'b1 : gauge_out;
    assign degas_line = degas_oe_n ? 1'b1 : degas_out;
endmodule : gci_partner

// [tb/gci_control_tb.sv]
// Self-checking testbench for the gauge control input block.
`timescale 1ns/1ns
module gci_control_tb;
    localparam int DEB = 4;
    localparam int SEC = 10;
    localparam int DEGAS_CYC = 2 * 60 * SEC;
    logic        aclk, awready, wready, bvalid, arready, rvalid, filament_on, emis_high, degas_active;
    logic        gauge_stat_out, gauge_stat_oe_n, degas_stat_out, degas_stat_oe_n, gauge_line, degas_line;
    logic        aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
    logic        rready = 1'b0, chatter = 1'b0, hit_a, hit_w, hit_r;
    logic [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hF;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic [2:0]  panel_n = 3'h7, req = 3'h0, din_n;
    logic [1:0]  bresp, rresp, rs;
    int          fail_count = 0, samples_checked = 0, n;

    gci_control #(.DEBOUNCE_CYCLES(DEB), .SECOND_CYCLES(SEC)) dut (
        .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
        .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .din_n, .panel_n,
        .filament_on, .emis_high, .degas_active, .gauge_stat_out, .gauge_stat_oe_n, .degas_stat_out,
        .degas_stat_oe_n
    );
    gci_partner far (
        .aclk, .req, .chatter, .gauge_oe_n(gauge_stat_oe_n), .gauge_out(gauge_stat_out),
        .degas_oe_n(degas_stat_oe_n), .degas_out(degas_stat_out), .din_n, .gauge_line, .degas_line
    );

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    task automatic conclude();
        $display("Checks %0d, mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : conclude

    task automatic stall();
        fail_count++;
        $display("[FAIL] %0t wait timed out", $time);
        conclude();
    endtask : stall

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    task automatic axi_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int i = 0; i < 50; i++) begin
            @(negedge aclk);
            hit_a = awvalid && awready === 1'b1;
            hit_w = wvalid && wready === 1'b1;
            hit_r = bvalid === 1'b1;
            rs = bresp;
            @(posedge aclk);
            if (hit_a) awvalid <= 1'b0;
            if (hit_w) wvalid <= 1'b0;
            if (hit_r) begin
                bready <= 1'b0;
                return;
            end
        end
        stall();
    endtask : axi_write

    task automatic axi_read(input logic [3:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int i = 0; i < 50; i++) begin
            @(negedge aclk);
            hit_a = arvalid && arready === 1'b1;
            hit_r = rvalid === 1'b1;
            rd = rdata;
            rs = rresp;
            @(posedge aclk);
            if (hit_a) arvalid <= 1'b0;
            if (hit_r) begin
                rready <= 1'b0;
                return;
            end
        end
        stall();
    endtask : axi_read

    function automatic logic pick(input int k);
        case (k)
            0: return filament_on;
            1: return emis_high;
            default: return degas_active;
        endcase
    endfunction : pick

    task automatic wait_for(input int k, input logic v, input int lim);
        for (n = 1; n <= lim; n++) begin
            @(negedge aclk);
            if (pick(k) === v) return;
        end
        stall();
    endtask : wait_for

    task automatic press(input int b);
        @(posedge aclk) panel_n[b] <= 1'b0;
        repeat (DEB + 6) @(posedge aclk);
        panel_n[b] <= 1'b1;
    endtask : press

    task automatic t_reset();
        @(negedge aclk);
        check(filament_on, 1'b0, "filament after reset");
        check(gauge_line, 1'b1, "gauge line after reset");
        axi_read(gci_pkg::ADDR_CONFIG);
        check(rd, 32'h8, "config reset");
        axi_read(gci_pkg::ADDR_STATUS);
        check(rd[2:0], 3'h0, "status reset");
    endtask : t_reset

    task automatic t_gauge();
        @(posedge aclk) req <= 3'b001;
        wait_for(0, 1'b1, DEB + 10);
        check(n >= DEB + 2, 1'b1, "gauge before debounce");
        check(gauge_line, 1'b0, "gauge line on");
        repeat (40) @(posedge aclk);
        check(filament_on, 1'b1, "filament held");
        axi_read(gci_pkg::ADDR_STATUS);
        check(rd[2:0], 3'h1, "status gauge");
        @(posedge aclk) req <= 3'b000;
        wait_for(0, 1'b0, DEB + 10);
        check(gauge_line, 1'b1, "gauge line off");
        @(posedge aclk) req <= 3'b100;
        wait_for(1, 1'b1, DEB + 10);
        @(posedge aclk) req <= 3'b000;
        wait_for(1, 1'b0, DEB + 10);
        @(posedge aclk) chatter <= 1'b1;
        repeat (12) begin
            @(negedge aclk);
            check(filament_on, 1'b0, "bounce during chatter");
        end
        @(posedge aclk) chatter <= 1'b0;
        repeat (DEB + 10) @(posedge aclk);
        check(filament_on, 1'b0, "bounce ignored");
    endtask : t_gauge

    task automatic t_degas();
        @(posedge aclk) req <= 3'b010;
        wait_for(2, 1'b1, DEB + 10);
        check(degas_line, 1'b0, "degas line on");
        @(posedge aclk) req <= 3'b000;
        wait_for(2, 1'b0, DEGAS_CYC + 50);
        check(n >= DEGAS_CYC - 3 && n <= DEGAS_CYC + 3, 1'b1, "degas length");
        check(degas_line, 1'b1, "degas line off");
        @(posedge aclk) req <= 3'b010;
        wait_for(2, 1'b1, DEB + 10);
        wait_for(2, 1'b0, DEGAS_CYC + 50);
        repeat (30) @(posedge aclk);
        check(degas_active, 1'b0, "held ground retrigger");
        req <= 3'b000;
        repeat (DEB + 5) @(posedge aclk);
        req <= 3'b010;
        wait_for(2, 1'b1, DEB + 10);
        @(posedge aclk) req <= 3'b000;
        wait_for(2, 1'b0, DEGAS_CYC + 50);
    endtask : t_degas

    task automatic t_select();
        axi_write(gci_pkg::ADDR_CONFIG, 32'h2);
        check(rs, gci_pkg::RESP_OKAY, "config write");
        @(posedge aclk) req <= 3'b001;
        repeat (DEB + 10) @(posedge aclk);
        check(filament_on, 1'b0, "pin ignored in serial mode");
        axi_write(gci_pkg::ADDR_COMMAND, 32'h3);
        wait_for(0, 1'b1, 10);
        check(emis_high, 1'b1, "serial emission");
        axi_write(gci_pkg::ADDR_COMMAND, 32'h7);
        wait_for(2, 1'b1, 10);
        wait_for(2, 1'b0, DEGAS_CYC + 50);
        check(n >= DEGAS_CYC - 3 && n <= DEGAS_CYC + 3, 1'b1, "clamped degas length");
        axi_write(gci_pkg::ADDR_CONFIG, 32'h9);
        axi_write(gci_pkg::ADDR_COMMAND, 32'h0);
        repeat (5) @(posedge aclk);
        check(filament_on, 1'b1, "serial ignored in panel mode");
        press(0);
        wait_for(0, 1'b0, DEB + 10);
        press(2);
        wait_for(1, 1'b0, DEB + 10);
        press(1);
        wait_for(2, 1'b1, DEB + 10);
        axi_write(gci_pkg::ADDR_CONFIG, 32'hB);
        press(0);
        repeat (DEB + 6) @(posedge aclk);
        check(filament_on, 1'b0, "held select ignores pins and panel");
        @(posedge aclk) req <= 3'b000;
        axi_write(4'hC, 32'h1);
        check(rs, gci_pkg::RESP_SLVERR, "unmapped write");
        axi_read(4'hC);
        check(rs, gci_pkg::RESP_SLVERR, "unmapped read");
    endtask : t_select

    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_gauge();
        t_degas();
        t_select();
        conclude();
    end
endmodule : gci_control_tb
